// [design/arfc_accum.sv]
// sample accumulator with series counter
// assumes sampleValid pulses one cycle per finished conversion
`timescale 1ns/1ps
module arfc_accum (
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire arfc_pkg::arfc_rpt_t repeatCode,
    input  wire logic                sampleValid,
    input  wire logic [11:0]         sample,
    output logic                     sumDone,
    output logic [15:0]              sum
);
    import arfc_pkg::*;

    typedef struct packed {
        logic [15:0] acc;
        logic [3:0]  count;
        logic        done;
        logic [15:0] sum;
    } arfc_acc_st_t;

    arfc_acc_st_t st;
    arfc_acc_st_t next_st;
    logic [3:0]   lastIdx;
    logic [15:0]  base;

    // last sample index of a series
    always_comb begin
        unique case (repeatCode)
            ARFC_RPT1:  lastIdx = 4'h0;
            ARFC_RPT4:  lastIdx = 4'h3;
            ARFC_RPT8:  lastIdx = 4'h7;
            ARFC_RPT16: lastIdx = 4'hF;
        endcase
    end

    // sum samples, publish only at series end
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        // first sample of series starts from zero
        base = (st.count == 4'h0) ? 16'h0000 : st.acc;
        if (sampleValid) begin
            next_st.acc = base + {4'h0, sample};
            if (st.count >= lastIdx) begin
                next_st.sum   = base + {4'h0, sample};
                next_st.done  = 1'b1;
                next_st.count = 4'h0;
            end else begin
                next_st.count = st.count + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sumDone = st.done;
    assign sum     = st.sum;
endmodule

// [design/arfc_pkg.sv]
// constants shared by the converter result and reference control block
// assumes a 32-bit classic wishbone slave port, byte address map
//
// Overview of operation
// - With a repeat count of one each 12-bit sample is the result, refreshed after every conversion.
// - Justify select 0 puts the sample in bits 11:0, 1 puts it in bits 15:4 when the repeat count is one.
// - Result bits not used by alignment or accumulation read as zero.
// - The repeat count field selects summing 4, 8 or 16 samples into an unsigned result.
// - With repeat above one the result updates only after the last sample of the series.
// - Input select codes map to port pins from zero up, then the temperature sensor, 11001 to 11111 ground.
// - Reference control bit 2 enables the temperature sensor; disabled, its channel is meaningless.
// - Reference control bit 4 selects 1.5 V when 0 and the higher level when 1.
package arfc_pkg;
    // byte addresses
    localparam logic [7:0] ADDR_INPUT_SEL  = 8'hBB;
    localparam logic [7:0] ADDR_REF_CTRL   = 8'hD1;
    localparam logic [7:0] ADDR_RES_HIGH   = 8'hC0;
    localparam logic [7:0] ADDR_RES_LOW    = 8'hC4;
    localparam logic [7:0] ADDR_CONV_CTRL  = 8'hC8;
    localparam logic [7:0] ADDR_CONV_CFG   = 8'hCC;
    // reset values
    localparam logic [4:0] RST_INPUT_SEL   = 5'h1F;
    localparam logic [7:0] RST_REF_CTRL    = 8'h00;
    // field positions
    localparam int         BIT_JUSTIFY     = 2;
    localparam int         BIT_TEMP_EN     = 2;
    localparam int         BIT_REF_LEVEL   = 4;
    localparam int         BIT_REF_SOURCE  = 3;
    localparam int         POS_REPEAT      = 1;
    // input select decode
    localparam logic [4:0] SEL_TEMP        = 5'h18;
    localparam logic [4:0] SEL_GND_FIRST   = 5'h1A;
    localparam logic [4:0] PIN_COUNT       = 5'h18;
    // repeat count field codes
    typedef enum logic [1:0] {
        ARFC_RPT1  = 2'h0,
        ARFC_RPT4  = 2'h1,
        ARFC_RPT8  = 2'h2,
        ARFC_RPT16 = 2'h3
    } arfc_rpt_t;
endpackage

// [design/arfc_top.sv]
// converter result formatting and reference control, wishbone slave
// assumes a synchronous converter core giving a pulse per sample
`timescale 1ns/1ps
module arfc_top (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sampleValid,
    input  wire logic [11:0] sample,
    output logic [4:0]       inputSelect,
    output logic [4:0]       pinSelect,
    output logic             pinRouted,
    output logic             tempRouted,
    output logic             groundRouted,
    output logic             tempSensorEnable,
    output logic             referenceLevelSelect,
    output logic             referenceSourceSelect,
    output logic [7:0]       referenceControl,
    output logic             resultUpdated
);
    import arfc_pkg::*;

    typedef struct packed {
        logic [4:0]  inSel;
        logic [7:0]  refCtl;
        logic [7:0]  convCtl;
        logic [7:0]  convCfg;
        logic [15:0] result;
        logic        updated;
        logic        ack;
        logic [31:0] rdata;
    } arfc_st_t;

    arfc_st_t    st;
    arfc_st_t    next_st;
    logic        sumDone;
    logic [15:0] sum;
    logic        justify;
    arfc_rpt_t   repeatCode;
    logic        access;
    logic        lane0;
    logic [7:0]  rdByte;
    logic [15:0] formatted;

    assign justify    = st.convCtl[BIT_JUSTIFY];
    assign repeatCode = arfc_rpt_t'(st.convCfg[POS_REPEAT +: 2]);

    // series accumulator
    arfc_accum u_accum (
        .clk_sys     (clk_sys),
        .arst_n      (arst_n),
        .repeatCode  (repeatCode),
        .sampleValid (sampleValid),
        .sample      (sample),
        .sumDone     (sumDone),
        .sum         (sum)
    );

    // alignment: left only for single samples, unused bits zero
    always_comb begin
        if (justify && repeatCode == ARFC_RPT1) begin
            formatted = {sum[11:0], 4'h0};
        end else begin
            formatted = sum;
        end
    end

    // read mux for one byte register
    always_comb begin
        unique case (wb_adr_i)
            ADDR_INPUT_SEL: rdByte = {3'h0, st.inSel};
            ADDR_REF_CTRL:  rdByte = st.refCtl;
            ADDR_RES_HIGH:  rdByte = st.result[15:8];
            ADDR_RES_LOW:   rdByte = st.result[7:0];
            ADDR_CONV_CTRL: rdByte = st.convCtl;
            ADDR_CONV_CFG:  rdByte = st.convCfg;
            default:        rdByte = 8'h00;
        endcase
    end

    assign access = wb_cyc_i & wb_stb_i & ~st.ack;
    assign lane0  = wb_sel_i[0];

    // register writes, result capture, bus answer
    always_comb begin
        next_st = st;
        next_st.ack = access;
        next_st.updated = 1'b0;
        if (access) begin
            next_st.rdata = {24'h000000, rdByte};
        end
        if (access && wb_we_i && lane0) begin
            unique case (wb_adr_i)
                ADDR_INPUT_SEL: next_st.inSel   = wb_dat_i[4:0];
                ADDR_REF_CTRL:  next_st.refCtl  = wb_dat_i[7:0];
                ADDR_CONV_CTRL: next_st.convCtl = wb_dat_i[7:0];
                ADDR_CONV_CFG:  next_st.convCfg = wb_dat_i[7:0];
                default: ;
            endcase
        end
        // result bytes refresh once per finished series
        if (sumDone) begin
            next_st.result  = formatted;
            next_st.updated = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st        <= '0;
            st.inSel  <= RST_INPUT_SEL;
            st.refCtl <= RST_REF_CTRL;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign resultUpdated = st.updated;

    // channel routing decode
    assign inputSelect  = st.inSel;
    assign pinRouted    = st.inSel < PIN_COUNT;
    assign pinSelect    = pinRouted ? st.inSel : 5'h00;
    assign tempRouted   = st.inSel == SEL_TEMP;
    assign groundRouted = st.inSel >= SEL_GND_FIRST
                          || st.inSel == SEL_TEMP + 5'h01;

    // reference control outputs
    assign tempSensorEnable      = st.refCtl[BIT_TEMP_EN];
    assign referenceLevelSelect  = st.refCtl[BIT_REF_LEVEL];
    assign referenceSourceSelect = st.refCtl[BIT_REF_SOURCE];
    assign referenceControl      = st.refCtl;
endmodule

// [verif/arfc_bench.sv]
// bench for arfc_top: registers over wishbone, samples by pulse
// assumes the checker binds itself to arfc_top
`timescale 1ns/1ps
module arfc_bench;
    import arfc_pkg::*;
    logic        clk_sys = 0, arst_n = 0, cyc = 0, we = 0, sv = 0;
    logic        ack, upd, pinR, tmpR, gndR, tEn, rLv, rSr;
    logic [7:0]  adr = 0, q, h;
    logic [31:0] dat = 0, datO;
    logic [11:0] smpl = 0;
    logic [4:0]  pSel, iSel;
    logic [7:0]  rCtl;
    logic [3:0]  sel = 4'h1;
    int          err_total = 0, cmp_count = 0, nUpd = 0, nClk = 0;
    arfc_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .sampleValid(sv),
        .sample(smpl), .inputSelect(iSel), .pinSelect(pSel), .pinRouted(pinR),
        .tempRouted(tmpR), .groundRouted(gndR), .tempSensorEnable(tEn),
        .referenceLevelSelect(rLv), .referenceSourceSelect(rSr),
        .referenceControl(rCtl), .resultUpdated(upd));
    initial forever #2.5 clk_sys = ~clk_sys;
    // counts update pulses and cuts a hang short
    always @(posedge clk_sys) begin
        nClk++;
        if (upd === 1'b1) nUpd++;
        if (nClk == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [15:0] s, e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, d);
        int n = 0;
        cyc <= 1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do @(posedge clk_sys); while (ack !== 1'b1 && ++n < 50);
        if (n == 50) err_total++;
        q = datO[7:0];
        cyc <= 0;
        @(posedge clk_sys);
    endtask
    // one conversion; sample line scrambled afterwards
    task automatic pulse(input logic [11:0] v);
        sv <= 1;
        smpl <= v;
        @(posedge clk_sys);
        sv <= 0;
        smpl <= ~v;
        repeat (4) @(posedge clk_sys); // update pulse counted before return
    endtask
    task automatic res(input logic [15:0] e);
        wb(0, ADDR_RES_HIGH, 0);
        h = q;
        wb(0, ADDR_RES_LOW, 0);
        chk("result", {h, q}, e);
    endtask
    task automatic tReset;
        wb(0, ADDR_INPUT_SEL, 0);
        chk("input select", q, 8'h1F);
        chk("ground", gndR, 1);
        wb(0, ADDR_REF_CTRL, 0);
        chk("reference", q, 8'h00);
        wb(0, 8'h00, 0);
        chk("unmapped", q, 8'h00);
        $display("reset test done");
    endtask
    task automatic tRoute;
        logic [4:0] c[6] = '{5'h00, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1F};
        foreach (c[i]) begin
            wb(1, ADDR_INPUT_SEL, {3'h7, c[i]});
            wb(0, ADDR_INPUT_SEL, 0);
            chk("select", q, {3'h0, c[i]});
            chk("select port", iSel, c[i]);
            chk("route", {pinR, tmpR, gndR},
                {c[i] < 24, c[i] == 24, c[i] > 24});
            chk("pin", pSel, c[i] < 24 ? c[i] : 5'h0);
        end
        $display("route test done");
    endtask
    task automatic tRef;
        wb(1, ADDR_REF_CTRL, 8'h14);
        chk("ref bits", {tEn, rLv, rSr}, 3'b110);
        chk("ref reg", rCtl, 8'h14);
        wb(1, ADDR_REF_CTRL, 8'h08);
        chk("ref bits", {tEn, rLv, rSr}, 3'b001);
        sel <= 4'h0;
        wb(1, ADDR_REF_CTRL, 8'hFF);
        sel <= 4'h1;
        chk("ref masked", rCtl, 8'h08);
        $display("reference test done");
    endtask
    task automatic tJust;
        wb(1, ADDR_CONV_CFG, 0);
        wb(1, ADDR_CONV_CTRL, 0);
        pulse(12'hFFF);
        res(16'h0FFF);
        wb(1, ADDR_CONV_CTRL, 8'h04);
        pulse(12'hFFF);
        res(16'hFFF0);
        pulse(12'h7FF);
        res(16'h7FF0);
        $display("justify test done");
    endtask
    // two series per count of 4, 8 and 16, second must not carry the first
    task automatic tAcc;
        int u;
        wb(1, ADDR_CONV_CTRL, 0); // right aligned while summing
        for (int c = 1; c < 4; c++) begin
            wb(1, ADDR_CONV_CFG, 8'(c * 2));
            for (int k = 0; k < 2; k++) begin
                u = nUpd;
                repeat (2 << c) pulse(k ? 12'h7FF : 12'hFFF);
                chk("updates", 16'(nUpd - u), 1);
                res(16'((2 << c) * (k ? 12'h7FF : 12'hFFF)));
            end
        end
        $display("accumulate test done");
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1;
        @(posedge clk_sys);
        tReset();
        tRoute();
        tRef();
        tJust();
        tAcc();
        end_sim();
    end
endmodule

// [verif/arfc_sva.sv]
// assertions on the ports of arfc_top
// assumes one clock domain; bound to every arfc_top below
`timescale 1ns/1ps
module arfc_sva (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        sampleValid,
    input wire logic [4:0]  inputSelect,
    input wire logic [4:0]  pinSelect,
    input wire logic        pinRouted,
    input wire logic        tempRouted,
    input wire logic        groundRouted,
    input wire logic        tempSensorEnable,
    input wire logic        referenceLevelSelect,
    input wire logic [7:0]  referenceControl,
    input wire logic        resultUpdated
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // request taken, then a one-cycle answer
    sequence sReq; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence sAck; wb_ack_o ##1 !wb_ack_o; endsequence
    a_ack_pulse: assert property (sReq |=> sAck)
        else $error("ack not one pulse");
    a_read_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_temp_en: assert property (tempSensorEnable == referenceControl[2])
        else $error("sensor enable wrong");
    a_ref_level: assert property (referenceLevelSelect == referenceControl[4])
        else $error("reference level wrong");
    a_pin_route: assert property (inputSelect < 5'h18 |-> pinRouted && pinSelect == inputSelect)
        else $error("pin route wrong");
    a_temp_route: assert property (inputSelect == 5'h18 |-> tempRouted && !pinRouted)
        else $error("sensor route wrong");
    a_gnd_route: assert property (inputSelect >= 5'h1A |-> groundRouted && !tempRouted)
        else $error("ground route wrong");
    a_upd_cause: assert property (resultUpdated |-> $past(sampleValid, 2))
        else $error("update without sample");
endmodule
bind arfc_top arfc_sva u_sva (.clk_sys, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_dat_o, .sampleValid, .inputSelect, .pinSelect, .pinRouted,
    .tempRouted, .groundRouted, .tempSensorEnable, .referenceLevelSelect,
    .referenceControl, .resultUpdated);
